// file: design/pec_event_select.sv
/*
 * event selection for one counter: picks the source named by event
 * number and unit mask, then applies threshold, invert and edge unless the threshold is zero.
 * assumes all event inputs are on the core clock.
 */
module pec_event_select (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_event,
    input wire logic [7:0] i_umask,
    input wire logic [7:0] i_threshold,
    input wire logic i_invert,
    input wire logic i_edge,
    input wire logic i_any_thread,
    input wire logic i_core_cycle,
    input wire logic i_ref_cycle,
    input wire logic [1:0] i_inst_retired,
    input wire logic i_llc_ref,
    input wire logic i_llc_miss,
    input wire logic i_branch_retired,
    input wire logic i_branch_mispredict,
    input wire logic i_blocked_forward_loads,
    input wire logic i_split_line_loads,
    input wire logic i_split_store_addr,
    input wire logic i_address_alias,
    input wire logic [7:0] i_dtlb_sub,
    input wire logic i_clear_recovery_cycles,
    input wire logic [2:0] i_uops_issued,
    input wire logic [2:0] i_uops_issued_other,
    output logic [pec_pkg::RAW_W-1:0] o_count
);
    import pec_pkg::*;

    // ------------------------------------------------------------
    // state: last threshold result, for edge detection
    // ------------------------------------------------------------
    typedef struct packed {
        logic hit;
    } pec_sel_state_t;

    pec_sel_state_t state_reg;
    pec_sel_state_t state_next;
    logic [RAW_W-1:0] raw;      // selected occurrences this cycle
    logic hit;                  // threshold comparison result

    // widen a small count to the raw width
    function automatic logic [RAW_W-1:0] wide(input logic [2:0] v);
        return {1'b0, v};
    endfunction

    // source decode
    always_comb begin
        raw = '0;
        case ({i_event, i_umask})
            {EV_CYCLES, UM_CORE_CYC}: raw = wide({2'h0, i_core_cycle});
            {EV_CYCLES, UM_REF_CYC}: raw = wide({2'h0, i_ref_cycle});
            {EV_INST_RET, UM_INST_RET}: raw = wide({1'b0, i_inst_retired});
            {EV_LLC, UM_LLC_REF}: raw = wide({2'h0, i_llc_ref});
            {EV_LLC, UM_LLC_MISS}: raw = wide({2'h0, i_llc_miss});
            {EV_BR_RET, UM_BR}: raw = wide({2'h0, i_branch_retired});
            {EV_BR_MISS, UM_BR}:
                raw = wide({2'h0, i_branch_mispredict});
            {EV_LD_BLOCK, UM_LD_BLOCK}:
                raw = wide({2'h0, i_blocked_forward_loads});
            {EV_SPLIT, UM_SPLIT_LD}:
                raw = wide({2'h0, i_split_line_loads});
            {EV_SPLIT, UM_SPLIT_ST}:
                raw = wide({2'h0, i_split_store_addr});
            {EV_ALIAS, UM_ALIAS}: raw = wide({2'h0, i_address_alias});
            {EV_RECOVER, UM_RECOVER}:
                raw = wide({2'h0, i_clear_recovery_cycles});
            {EV_UOPS, UM_UOPS_ANY}: begin
                // any-thread folds in the sibling thread's issue count
                raw = wide(i_uops_issued) + (i_any_thread ?
                    wide(i_uops_issued_other) : '0);
            end
            default: begin
                // union of the masked translation sub-events
                if (i_event == EV_DTLB) begin
                    raw = wide({2'h0, |(i_umask & i_dtlb_sub)});
                end
            end
        endcase
    end

    // threshold, invert and edge qualifiers
    always_comb begin
        state_next = state_reg;
        hit = i_invert ? ({4'h0, raw} < i_threshold)
                       : ({4'h0, raw} >= i_threshold);
        state_next.hit = hit;
        if (i_threshold == 8'h00) begin
            o_count = raw;
        end else if (i_edge) begin
            o_count = {3'h0, hit && !state_reg.hit};
        end else begin
            o_count = {3'h0, hit};
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// file: design/pec_perf_event_counter.sv
/*
 * two-counter performance event block with indicator pins.
 * each counter counts occurrences or clock duration of an event
 * chosen by event number and unit mask, gated by privilege.
 * assumes event sources, privilege and configuration are driven by
 * logic on the same core clock; no synchronisers are needed.
 */
module pec_perf_event_counter (
    input wire logic i_clk,
    input wire logic i_rst,
    // configuration word, latched every clock
    input wire logic [pec_pkg::CTL_W-1:0] i_counter_control_register,
    // upper event number bits beyond the six bit select field
    input wire logic [1:0] i_event_high_a,
    input wire logic [1:0] i_event_high_b,
    // per-counter qualifiers
    input wire logic [7:0] i_unit_mask_a,
    input wire logic [7:0] i_unit_mask_b,
    input wire logic [7:0] i_threshold_a,
    input wire logic [7:0] i_threshold_b,
    input wire logic i_invert_a,
    input wire logic i_invert_b,
    input wire logic i_edge_a,
    input wire logic i_edge_b,
    input wire logic i_any_thread_a,
    input wire logic i_any_thread_b,
    // software preset of the counters
    input wire logic i_preset_a,
    input wire logic i_preset_b,
    input wire logic [pec_pkg::CNT_W-1:0] i_preset_value,
    // clearing of the sticky overflow flags
    input wire logic i_overflow_clear_a,
    input wire logic i_overflow_clear_b,
    // privilege of the code now running
    input wire logic [1:0] i_current_privilege,
    // event sources of the core
    input wire logic i_core_cycle,
    input wire logic i_ref_cycle,
    input wire logic [1:0] i_inst_retired,
    input wire logic i_llc_ref,
    input wire logic i_llc_miss,
    input wire logic i_branch_retired,
    input wire logic i_branch_mispredict,
    input wire logic i_blocked_forward_loads,
    input wire logic i_split_line_loads,
    input wire logic i_split_store_addr,
    input wire logic i_address_alias,
    input wire logic [7:0] i_dtlb_sub,
    input wire logic i_clear_recovery_cycles,
    input wire logic [2:0] i_uops_issued,
    input wire logic [2:0] i_uops_issued_other,
    // results
    output logic [pec_pkg::CNT_W-1:0] o_event_counter_a,
    output logic [pec_pkg::CNT_W-1:0] o_event_counter_b,
    output logic o_indicator_pin_a,
    output logic o_indicator_pin_b,
    output logic o_overflow_a,
    output logic o_overflow_b
);
    import pec_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CTL_W-1:0] ctl;      // latched control word
        logic [CNT_W-1:0] cnt_a;    // counter a
        logic [CNT_W-1:0] cnt_b;    // counter b
        logic pin_a;                // indicator a
        logic pin_b;                // indicator b
        logic ovf_a;                // sticky overflow a
        logic ovf_b;                // sticky overflow b
    } pec_state_t;

    pec_state_t state_reg;
    pec_state_t state_next;

    // ------------------------------------------------------------
    // helper signals
    // ------------------------------------------------------------
    logic [RAW_W-1:0] raw_a;        // selected count, counter a
    logic [RAW_W-1:0] raw_b;        // selected count, counter b
    logic [7:0] event_a;            // full event number a
    logic [7:0] event_b;            // full event number b
    logic [CC_W-1:0] cc_a;          // counter control a
    logic [CC_W-1:0] cc_b;          // counter control b
    logic [RAW_W-1:0] inc_a;        // amount added this clock, a
    logic [RAW_W-1:0] inc_b;        // amount added this clock, b
    logic [CNT_W:0] sum_a;          // counter a plus carry
    logic [CNT_W:0] sum_b;          // counter b plus carry

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // privilege gate from the low two control bits
    function automatic logic priv_ok(
        input logic [CC_W-1:0] cc,
        input logic [1:0] prv
    );
        logic user;
        user = (prv == PRIV_USER);
        // middle bit covers privilege 3, low bit the rest
        return user ? cc[CC_USR_BIT] : cc[CC_SUP_BIT];
    endfunction

    // amount to add in one clock
    function automatic logic [RAW_W-1:0] step(
        input logic [CC_W-1:0] cc,
        input logic [1:0] prv,
        input logic [RAW_W-1:0] raw
    );
        logic [RAW_W-1:0] amount;
        amount = '0;
        if (priv_ok(cc, prv)) begin
            if (cc[CC_DUR_BIT]) begin
                // duration: one per clock the condition is true
                amount = (raw != '0) ? 4'h1 : 4'h0;
            end else begin
                // occurrence: every occurrence, even two at once
                amount = raw;
            end
        end
        return amount;
    endfunction

    // 41 bit sum, top bit is the carry out of bit 39
    function automatic logic [CNT_W:0] add(
        input logic [CNT_W-1:0] cnt,
        input logic [RAW_W-1:0] amount
    );
        return {1'b0, cnt} + {37'h0, amount};
    endfunction

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------

    // the select field holds six bits; the high two come from
    // separate ports so that event numbers above 3fh are reachable
    always_comb begin
        event_a = {i_event_high_a,
            state_reg.ctl[ES_A_LSB +: ES_W]};
        event_b = {i_event_high_b,
            state_reg.ctl[ES_B_LSB +: ES_W]};
        cc_a = state_reg.ctl[CC_A_LSB +: CC_W];
        cc_b = state_reg.ctl[CC_B_LSB +: CC_W];
    end

    // ------------------------------------------------------------
    // event selection, one per counter
    // ------------------------------------------------------------

    // counter a source
    pec_event_select u_sel_a (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_event(event_a),
        .i_umask(i_unit_mask_a),
        .i_threshold(i_threshold_a),
        .i_invert(i_invert_a),
        .i_edge(i_edge_a),
        .i_any_thread(i_any_thread_a),
        .i_core_cycle(i_core_cycle),
        .i_ref_cycle(i_ref_cycle),
        .i_inst_retired(i_inst_retired),
        .i_llc_ref(i_llc_ref),
        .i_llc_miss(i_llc_miss),
        .i_branch_retired(i_branch_retired),
        .i_branch_mispredict(i_branch_mispredict),
        .i_blocked_forward_loads(i_blocked_forward_loads),
        .i_split_line_loads(i_split_line_loads),
        .i_split_store_addr(i_split_store_addr),
        .i_address_alias(i_address_alias),
        .i_dtlb_sub(i_dtlb_sub),
        .i_clear_recovery_cycles(i_clear_recovery_cycles),
        .i_uops_issued(i_uops_issued),
        .i_uops_issued_other(i_uops_issued_other),
        .o_count(raw_a)
    );

    // counter b source
    pec_event_select u_sel_b (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_event(event_b),
        .i_umask(i_unit_mask_b),
        .i_threshold(i_threshold_b),
        .i_invert(i_invert_b),
        .i_edge(i_edge_b),
        .i_any_thread(i_any_thread_b),
        .i_core_cycle(i_core_cycle),
        .i_ref_cycle(i_ref_cycle),
        .i_inst_retired(i_inst_retired),
        .i_llc_ref(i_llc_ref),
        .i_llc_miss(i_llc_miss),
        .i_branch_retired(i_branch_retired),
        .i_branch_mispredict(i_branch_mispredict),
        .i_blocked_forward_loads(i_blocked_forward_loads),
        .i_split_line_loads(i_split_line_loads),
        .i_split_store_addr(i_split_store_addr),
        .i_address_alias(i_address_alias),
        .i_dtlb_sub(i_dtlb_sub),
        .i_clear_recovery_cycles(i_clear_recovery_cycles),
        .i_uops_issued(i_uops_issued),
        .i_uops_issued_other(i_uops_issued_other),
        .o_count(raw_b)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    // counters, pins and overflow flags; a preset wins over
    // counting in the same clock and raises no pin
    always_comb begin
        state_next = state_reg;
        state_next.ctl = i_counter_control_register;
        inc_a = step(cc_a, i_current_privilege, raw_a);
        inc_b = step(cc_b, i_current_privilege, raw_b);
        sum_a = add(state_reg.cnt_a, inc_a);
        sum_b = add(state_reg.cnt_b, inc_b);

        // counter a
        if (i_preset_a) begin
            state_next.cnt_a = i_preset_value;
            state_next.pin_a = 1'b0;
        end else begin
            state_next.cnt_a = sum_a[CNT_W-1:0];
            if (state_reg.ctl[PC_A_BIT]) begin
                // overflow mode: one clock per carry out
                state_next.pin_a = sum_a[CNT_W];
            end else begin
                // increment mode: high exactly when it grows;
                // a duration event keeps it high throughout
                state_next.pin_a = (inc_a != '0);
            end
        end

        // counter b
        if (i_preset_b) begin
            state_next.cnt_b = i_preset_value;
            state_next.pin_b = 1'b0;
        end else begin
            state_next.cnt_b = sum_b[CNT_W-1:0];
            if (state_reg.ctl[PC_B_BIT]) begin
                state_next.pin_b = sum_b[CNT_W];
            end else begin
                state_next.pin_b = (inc_b != '0);
            end
        end

        // sticky overflow: a carry in the clearing clock still sets
        if (!i_preset_a && sum_a[CNT_W]) begin
            state_next.ovf_a = 1'b1;
        end else if (i_overflow_clear_a) begin
            state_next.ovf_a = 1'b0;
        end
        if (!i_preset_b && sum_b[CNT_W]) begin
            state_next.ovf_b = 1'b1;
        end else if (i_overflow_clear_b) begin
            state_next.ovf_b = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    // control word comes up all zero: both counters disabled
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg.ctl <= CTL_RST;
            state_reg.cnt_a <= CNT_RST;
            state_reg.cnt_b <= CNT_RST;
            state_reg.pin_a <= 1'b0;
            state_reg.pin_b <= 1'b0;
            state_reg.ovf_a <= 1'b0;
            state_reg.ovf_b <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // all outputs straight from the state register; the pins
    // show the increment, or the carry in overflow mode, in the same clock the counter moves
    always_comb begin
        o_event_counter_a = state_reg.cnt_a;
        o_event_counter_b = state_reg.cnt_b;
        o_indicator_pin_a = state_reg.pin_a;
        o_indicator_pin_b = state_reg.pin_b;
        o_overflow_a = state_reg.ovf_a;
        o_overflow_b = state_reg.ovf_b;
    end
endmodule

// file: design/pec_pkg.sv
/*
 * shared constants of the performance event counter: control word
 * layout, counter width, event and unit mask codes.
 * assumes one core clock and a synchronous active-high reset.
 */
package pec_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CNT_W = 40;          // counter width
    localparam int RAW_W = 4;           // per-cycle increment width
    localparam int CTL_W = 32;          // control word width
    localparam logic [CTL_W-1:0] CTL_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 40'h00_0000_0000;
    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int ES_A_LSB = 0;        // event select, counter a
    localparam int ES_B_LSB = 16;       // event select, counter b
    localparam int ES_W = 6;
    localparam int CC_A_LSB = 6;        // counter control, a
    localparam int CC_B_LSB = 22;       // counter control, b
    localparam int CC_W = 3;
    localparam int PC_A_BIT = 9;        // pin control, a
    localparam int PC_B_BIT = 25;       // pin control, b
    localparam int CC_DUR_BIT = 2;      // clocks versus events
    localparam int CC_USR_BIT = 1;      // privilege 3
    localparam int CC_SUP_BIT = 0;      // privileges 0 to 2
    localparam logic [1:0] PRIV_USER = 2'h3;
    // ------------------------------------------------------------
    // event numbers and unit masks
    // ------------------------------------------------------------
    localparam logic [7:0] EV_CYCLES = 8'h3c;
    localparam logic [7:0] UM_CORE_CYC = 8'h00;
    localparam logic [7:0] UM_REF_CYC = 8'h01;
    localparam logic [7:0] EV_INST_RET = 8'hc0;
    localparam logic [7:0] UM_INST_RET = 8'h00;
    localparam logic [7:0] EV_LLC = 8'h2e;
    localparam logic [7:0] UM_LLC_REF = 8'h4f;
    localparam logic [7:0] UM_LLC_MISS = 8'h41;
    localparam logic [7:0] EV_BR_RET = 8'hc4;
    localparam logic [7:0] EV_BR_MISS = 8'hc5;
    localparam logic [7:0] UM_BR = 8'h00;
    localparam logic [7:0] EV_LD_BLOCK = 8'h03;
    localparam logic [7:0] UM_LD_BLOCK = 8'h02;
    localparam logic [7:0] EV_SPLIT = 8'h05;
    localparam logic [7:0] UM_SPLIT_LD = 8'h01;
    localparam logic [7:0] UM_SPLIT_ST = 8'h02;
    localparam logic [7:0] EV_ALIAS = 8'h07;
    localparam logic [7:0] UM_ALIAS = 8'h01;
    localparam logic [7:0] EV_DTLB = 8'h08;
    localparam logic [7:0] EV_RECOVER = 8'h0d;
    localparam logic [7:0] UM_RECOVER = 8'h03;
    localparam logic [7:0] EV_UOPS = 8'h0e;
    localparam logic [7:0] UM_UOPS_ANY = 8'h01;
endpackage

// file: sim/pec_perf_event_counter_chk.sv
/*
 * port checker of the event counter block.
 * assumes one clock and a synchronous active-high reset.
 */
module pec_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [pec_pkg::CTL_W-1:0] i_counter_control_register,
    input wire logic i_preset_a,
    input wire logic i_preset_b,
    input wire logic [pec_pkg::CNT_W-1:0] i_preset_value,
    input wire logic i_overflow_clear_a,
    input wire logic [1:0] i_current_privilege,
    input wire logic [pec_pkg::CNT_W-1:0] o_event_counter_a,
    input wire logic [pec_pkg::CNT_W-1:0] o_event_counter_b,
    input wire logic o_indicator_pin_a,
    input wire logic o_indicator_pin_b,
    input wire logic o_overflow_a
);
    timeunit 1ns;
    timeprecision 1ns;
    import pec_pkg::*;
    // ------------------------------------------------------------
    // delayed copies of the inputs
    // ------------------------------------------------------------
    logic [CTL_W-1:0] ctl_d1, ctl_d2; // control, one and two back
    logic [1:0] priv_d; // privilege of the counted clock
    logic rst_d, pre_a_d, pre_b_d; // reset and preset, one back
    always_ff @(posedge i_clk) begin
        ctl_d1 <= i_counter_control_register;
        ctl_d2 <= ctl_d1;
        priv_d <= i_current_privilege;
        rst_d <= i_rst;
        pre_a_d <= i_preset_a;
        pre_b_d <= i_preset_b;
    end
    // plain counting step: no reset or preset behind it
    wire ok_a = !rst_d && !pre_a_d;
    wire ok_b = !rst_d && !pre_b_d;
    // enable by privilege: bit1 for user, bit0 for the rest
    wire en_a = (priv_d == PRIV_USER) ? ctl_d2[CC_A_LSB+1] : ctl_d2[CC_A_LSB];
    wire en_b = (priv_d == PRIV_USER) ? ctl_d2[CC_B_LSB+1] : ctl_d2[CC_B_LSB];
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    incr_pin_a_a:
        assert property (ok_a && !ctl_d2[PC_A_BIT] |-> o_indicator_pin_a ==
            (o_event_counter_a != $past(o_event_counter_a)))
        else $error("pin a vs step");
    incr_pin_b_a:
        assert property (ok_b && !ctl_d2[PC_B_BIT] |-> o_indicator_pin_b ==
            (o_event_counter_b != $past(o_event_counter_b)))
        else $error("pin b vs step");
    gate_a_a:
        assert property (ok_a && !en_a |-> $stable(o_event_counter_a))
        else $error("a moved disabled");
    gate_b_a:
        assert property (ok_b && !en_b |-> $stable(o_event_counter_b))
        else $error("b moved disabled");
    preset_load_a:
        assert property (i_preset_a |=> o_event_counter_a ==
            $past(i_preset_value) && !o_indicator_pin_a)
        else $error("preset a lost");
    ovf_sticky_a:
        assert property (o_overflow_a && !i_overflow_clear_a |=> o_overflow_a)
        else $error("ovf a dropped");
    ovf_set_a:
        assert property (ok_a && o_event_counter_a < $past(o_event_counter_a)
            |-> o_overflow_a && o_indicator_pin_a == ctl_d2[PC_A_BIT])
        else $error("wrap a unflagged");
    dur_step_a:
        assert property (ok_a && ctl_d2[CC_A_LSB+2] |->
            o_event_counter_a - $past(o_event_counter_a) <= 1)
        else $error("duration a step over 1");
endmodule
bind pec_perf_event_counter pec_chk chk_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_counter_control_register(i_counter_control_register),
    .i_preset_a(i_preset_a), .i_preset_b(i_preset_b),
    .i_preset_value(i_preset_value), .i_overflow_clear_a(i_overflow_clear_a),
    .i_current_privilege(i_current_privilege),
    .o_event_counter_a(o_event_counter_a), .o_overflow_a(o_overflow_a),
    .o_event_counter_b(o_event_counter_b),
    .o_indicator_pin_a(o_indicator_pin_a),
    .o_indicator_pin_b(o_indicator_pin_b));

// file: sim/pec_pin_watch.sv
/*
 * outside watcher of the two indicator pins: counts sampled high clocks.
 * assumes pins are sampled on the rising edge of the block clock.
 */
module pec_pin_watch (
    input wire logic i_clk,
    input wire logic i_clear,
    input wire logic i_pin_a,
    input wire logic i_pin_b,
    output logic [15:0] o_high_a,
    output logic [15:0] o_high_b
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // high clock tallies
    // ------------------------------------------------------------
    // one tick per high clock
    always_ff @(posedge i_clk) begin
        if (i_clear) begin
            o_high_a <= 16'h0;
            o_high_b <= 16'h0;
        end else begin
            o_high_a <= o_high_a + 16'(i_pin_a);
            o_high_b <= o_high_b + 16'(i_pin_b);
        end
    end
endmodule

// file: sim/tb_pec_perf_event_counter.sv
/*
 * self-checking bench: both counters get the same setup and must agree.
 * assumes inputs change at the falling edge, outputs settle by then.
 */
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    fail_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_pec_perf_event_counter;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst, inv, edg, anyt, pre, ovc; // clock and qualifiers
    logic [31:0] ctl; // control word
    logic [1:0] ev_hi, priv, inst;
    logic [7:0] umask, thr, dtlb;
    logic [10:0] src; // one-bit event sources, table order
    logic [2:0] uops, uops_o;
    logic [39:0] pval, cnt_a, cnt_b;
    logic pin_a, pin_b, ov_a, ov_b;
    logic [15:0] hi_a, hi_b; // pin clocks seen outside
    int fail_count = 0, tests_run = 0;
    // event number and unit mask of each one-bit source
    logic [7:0] tev [11] = '{8'h3c, 8'h3c, 8'h2e, 8'h2e, 8'hc4, 8'hc5,
        8'h03, 8'h05, 8'h05, 8'h07, 8'h0d};
    logic [7:0] tum [11] = '{8'h00, 8'h01, 8'h4f, 8'h41, 8'h00, 8'h00,
        8'h02, 8'h01, 8'h02, 8'h01, 8'h03};
    pec_perf_event_counter dut_u (.i_clk(i_clk), .i_rst(i_rst),
        .i_counter_control_register(ctl), .i_event_high_a(ev_hi),
        .i_event_high_b(ev_hi), .i_unit_mask_a(umask), .i_unit_mask_b(umask),
        .i_threshold_a(thr), .i_threshold_b(thr), .i_invert_a(inv),
        .i_invert_b(inv), .i_edge_a(edg), .i_edge_b(edg),
        .i_any_thread_a(anyt), .i_any_thread_b(anyt), .i_preset_a(pre),
        .i_preset_b(pre), .i_preset_value(pval), .i_overflow_clear_a(ovc),
        .i_overflow_clear_b(ovc), .i_current_privilege(priv),
        .i_core_cycle(src[0]), .i_ref_cycle(src[1]), .i_inst_retired(inst),
        .i_llc_ref(src[2]), .i_llc_miss(src[3]), .i_branch_retired(src[4]),
        .i_branch_mispredict(src[5]), .i_blocked_forward_loads(src[6]),
        .i_split_line_loads(src[7]), .i_split_store_addr(src[8]),
        .i_address_alias(src[9]), .i_dtlb_sub(dtlb),
        .i_clear_recovery_cycles(src[10]), .i_uops_issued(uops),
        .i_uops_issued_other(uops_o), .o_event_counter_a(cnt_a),
        .o_event_counter_b(cnt_b), .o_indicator_pin_a(pin_a),
        .o_indicator_pin_b(pin_b), .o_overflow_a(ov_a), .o_overflow_b(ov_b));
    pec_pin_watch watch_u (.i_clk(i_clk), .i_clear(pre), .i_pin_a(pin_a),
        .i_pin_b(pin_b), .o_high_a(hi_a), .o_high_b(hi_b));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // new setup under preset
    task automatic cfg(input logic [7:0] ev, um, input logic [2:0] cc,
        input logic pc);
        ctl = {6'h0, pc, cc, ev[5:0], 6'h0, pc, cc, ev[5:0]};
        ev_hi = ev[7:6];
        umask = um;
        pval = 40'h0;
        pre = 1;
        ovc = 1;
        cyc(2);
        pre = 0;
        ovc = 0;
    endtask
    // idle clock, then counts
    task automatic chk(input logic [39:0] n, input logic [15:0] p);
        cyc(1);
        `CHK("cnt_a", n, cnt_a)
        `CHK("cnt_b", n, cnt_b)
        `CHK("pin_a", p, hi_a)
        `CHK("pin_b", p, hi_b)
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        i_clk = 0;
        forever #10 i_clk = ~i_clk;
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {i_rst, inv, edg, anyt, pre, ovc} = 6'h20;
        {ctl, ev_hi, priv, inst, umask, thr, dtlb} = '0;
        {src, uops, uops_o, pval} = '0;
        cyc(6);
        i_rst = 0;
        // each source, then all others
        for (int i = 0; i < 11; i++) begin
            thr = (i == 10) ? 8'h1 : 8'h0;
            cfg(tev[i], tum[i], 3'h3, 1'b0);
            src = 11'h1 << i;
            cyc(2);
            src = ~(11'h1 << i);
            cyc(1);
            src = 0;
            chk(40'h2, 16'h2);
        end
        edg = 1; // one rise in three clocks
        cfg(8'h0d, 8'h03, 3'h3, 1'b0);
        src[10] = 1;
        cyc(3);
        {src, thr, edg} = '0;
        chk(40'h1, 16'h1);
        cfg(8'h3c, 8'h00, 3'h2, 1'b0); // user only
        src = 11'h1;
        cyc(2);
        priv = 2'h3;
        cyc(1);
        {priv, src} = '0;
        chk(40'h1, 16'h1);
        cfg(8'hc0, 8'h00, 3'h3, 1'b0); // several retire per clock
        inst = 2'h2;
        cyc(1);
        inst = 2'h3;
        cyc(1);
        inst = 0;
        chk(40'h5, 16'h2);
        cfg(8'hc0, 8'h00, 3'h7, 1'b0); // duration of a wide source
        inst = 2'h3;
        cyc(3);
        inst = 0;
        chk(40'h3, 16'h3);
        cfg(8'h08, 8'h0e, 3'h3, 1'b0); // union, then two unmasked bits
        dtlb = 8'h06;
        cyc(1);
        dtlb = 8'h90;
        cyc(1);
        dtlb = 0;
        chk(40'h1, 16'h1);
        cfg(8'h0e, 8'h01, 3'h3, 1'b0); // issued, then whole pair
        {uops, uops_o} = 6'h1a;
        cyc(1);
        anyt = 1;
        cyc(1);
        {uops, uops_o, anyt} = '0;
        chk(40'h8, 16'h2);
        {thr, inv} = 9'h3; // stall clocks
        cfg(8'h0e, 8'h01, 3'h3, 1'b0);
        cyc(2);
        uops = 3'h1;
        cyc(1);
        {uops, thr, inv} = '0;
        chk(40'h2, 16'h2);
        cfg(8'h3c, 8'h00, 3'h3, 1'b1); // wrap from all ones
        pval = 40'hff_ffff_ffff;
        pre = 1;
        cyc(1);
        pre = 0;
        src = 11'h1;
        cyc(2);
        src = 0;
        chk(40'h1, 16'h1);
        `CHK("ovf", 2'h3, {ov_a, ov_b})
        ovc = 1;
        cyc(1);
        ovc = 0;
        cyc(1);
        `CHK("ovf", 2'h0, {ov_a, ov_b})
        test_done();
    end
endmodule
